// [hw/mcsr_pkg.sv]
// package for the mac control and statistics register group: offsets, fields, resets, carriers
// assumes a word-addressed register port with byte addresses on reg_addr_i
package mcsr_pkg;

  // register byte addresses
  localparam logic [8:0] MCSR_OFF_MAC_CTL = 9'h154;
  localparam logic [8:0] MCSR_OFF_CNT_DATA = 9'h164;
  localparam logic [8:0] MCSR_OFF_CNT_SEL = 9'h168;
  localparam logic [8:0] MCSR_OFF_CNT_MGMT = 9'h16C;
  localparam logic [8:0] MCSR_OFF_SNOOP = 9'h170;
  localparam logic [8:0] MCSR_OFF_IDC = 9'h180;

  // mac control low bits
  localparam int MCSR_MC_DUPLEX = 6;
  localparam int MCSR_MC_SQE = 5;
  localparam int MCSR_MC_DEFER_DIS = 4;
  localparam int MCSR_MC_FCS_STRIP = 1;
  localparam int MCSR_MC_FCS_NOCHK = 0;
  localparam logic MCSR_RST_DUPLEX = 1'b1;
  localparam logic MCSR_RST_DEFER_DIS = 1'b1;

  // counter select and control fields
  localparam int MCSR_CS_AUTO_INC = 10;
  localparam int MCSR_CS_CLR_RD = 9;
  localparam int MCSR_CS_WR_MODE = 8;
  localparam int MCSR_CS_ADDR_LSB = 0;
  localparam int MCSR_CNT_ADDR_W = 6;

  // counter address map
  localparam logic [5:0] MCSR_TX_FIRST = 6'h00;
  localparam logic [5:0] MCSR_TX_LAST = 6'h0E;
  localparam logic [5:0] MCSR_RX_FIRST = 6'h0F;
  localparam logic [5:0] MCSR_RX_LAST = 6'h25;
  localparam int MCSR_NUM_CNT = 38;

  // counter management bits
  localparam int MCSR_CM_FREEZE = 2;
  localparam int MCSR_CM_CLR_RX = 1;
  localparam int MCSR_CM_CLR_TX = 0;

  // snoop pointer and interrupt delay widths
  localparam int MCSR_SNOOP_W = 7;
  localparam int MCSR_IDC_W = 24;

  // mac control low bits as one carrier
  typedef struct packed {
    logic duplex_select;
    logic sqe_enable;
    logic defer_check_disable;
    logic fcs_strip;
    logic fcs_check_disable;
  } mcsr_mac_ctl_t;

  localparam mcsr_mac_ctl_t MCSR_MAC_CTL_RST = '{
    duplex_select: MCSR_RST_DUPLEX,
    sqe_enable: 1'b0,
    defer_check_disable: MCSR_RST_DEFER_DIS,
    fcs_strip: 1'b0,
    fcs_check_disable: 1'b0
  };

  // counter select and control carrier
  typedef struct packed {
    logic auto_inc;
    logic clr_on_read;
    logic wr_mode;
    logic [5:0] addr;
  } mcsr_cnt_sel_t;

endpackage

// [hw/mcsr_stat_cnt.sv]
// one statistics counter with a freeze buffer, clear and host load
// assumes evt_i is a one-cycle pulse per countable event in the ref_clk_i domain
`timescale 1ns/1ns

module mcsr_stat_cnt #(
  parameter int CNT_W = 32,
  parameter int PEND_W = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic evt_i,
  input wire logic freeze_i,
  input wire logic clr_i,
  input wire logic load_i,
  input wire logic [CNT_W-1:0] load_val_i,
  // state
  output logic [CNT_W-1:0] cnt_o,
  output logic pend_o
);

  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [PEND_W-1:0] pend_q, pend_d;

  // next value: frozen events collect in pend, then fold in on release
  always_comb
  begin
    cnt_d = cnt_q;
    pend_d = pend_q;
    if (load_i)
    begin
      cnt_d = load_val_i;
      pend_d = '0;
    end
    else if (clr_i)
    begin
      // an event in the clearing cycle still counts
      cnt_d = freeze_i ? '0 : CNT_W'(evt_i);
      pend_d = freeze_i ? PEND_W'(evt_i) : '0;
    end
    else if (freeze_i)
    begin
      // saturates: a freeze longer than 2**PEND_W-1 events loses counts
      if (evt_i && (pend_q != '1))
        pend_d = pend_q + PEND_W'(1);
    end
    else
    begin
      cnt_d = cnt_q + CNT_W'(pend_q) + CNT_W'(evt_i);
      pend_d = '0;
    end
  end

  // state registers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cnt_q <= '0;
      pend_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
      pend_q <= pend_d;
    end
  end

  assign cnt_o = cnt_q;
  assign pend_o = (pend_q != '0);

endmodule

// [hw/mcsr_regs.sv]
// mac control low bits, statistics counter window, snoop pointer and rx interrupt delay
// assumes a synchronous single-cycle register port; reads answer one cycle later
`timescale 1ns/1ns

module mcsr_regs #(
  parameter int CNT_W = 32,
  parameter int PEND_W = 8,
  parameter int NUM_CNT = mcsr_pkg::MCSR_NUM_CNT
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [8:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // mac controls
  output mcsr_pkg::mcsr_mac_ctl_t mac_ctl_o,
  // statistics events, one pulse per event
  input wire logic [NUM_CNT-1:0] cnt_evt_i,
  // snoop window
  output logic [mcsr_pkg::MCSR_SNOOP_W-1:0] snoop_block_o,
  // receive interrupt timing
  input wire logic rx_done_i,
  input wire logic byte_tick_i,
  output logic rx_int_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  if (CNT_W != 32)
  begin : g_chk_w
    $error("counter width must match the 32-bit data port");
  end
  if (PEND_W < 1 || PEND_W > CNT_W)
  begin : g_chk_p
    $error("freeze buffer width out of range");
  end
  if (NUM_CNT != int'(mcsr_pkg::MCSR_RX_LAST) + 1)
  begin : g_chk_n
    $error("counter count must cover the whole address map");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  logic wr_mac, wr_data, wr_sel, wr_mgmt, wr_snoop, wr_idc;
  logic rd_data;

  // one strobe per register, unmapped offsets do nothing
  always_comb
  begin
    wr_mac = reg_wr_i && (reg_addr_i == mcsr_pkg::MCSR_OFF_MAC_CTL);
    wr_data = reg_wr_i && (reg_addr_i == mcsr_pkg::MCSR_OFF_CNT_DATA);
    wr_sel = reg_wr_i && (reg_addr_i == mcsr_pkg::MCSR_OFF_CNT_SEL);
    wr_mgmt = reg_wr_i && (reg_addr_i == mcsr_pkg::MCSR_OFF_CNT_MGMT);
    wr_snoop = reg_wr_i && (reg_addr_i == mcsr_pkg::MCSR_OFF_SNOOP);
    wr_idc = reg_wr_i && (reg_addr_i == mcsr_pkg::MCSR_OFF_IDC);
    rd_data = reg_rd_i && (reg_addr_i == mcsr_pkg::MCSR_OFF_CNT_DATA);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control registers

  mcsr_pkg::mcsr_mac_ctl_t mac_q, mac_d;
  mcsr_pkg::mcsr_cnt_sel_t sel_q, sel_d;
  logic freeze_q, freeze_d;
  logic [mcsr_pkg::MCSR_SNOOP_W-1:0] snoop_q, snoop_d;
  logic [mcsr_pkg::MCSR_IDC_W-1:0] idc_q, idc_d;
  logic data_acc;
  logic [5:0] addr_inc;

  // any read or write of the data port is one access
  assign data_acc = rd_data || wr_data;
  assign addr_inc = (sel_q.addr == mcsr_pkg::MCSR_RX_LAST) ? mcsr_pkg::MCSR_TX_FIRST
                    : sel_q.addr + 6'h01;

  // next values for software-written control
  always_comb
  begin
    mac_d = mac_q;
    sel_d = sel_q;
    freeze_d = freeze_q;
    snoop_d = snoop_q;
    idc_d = idc_q;
    if (wr_mac)
    begin
      mac_d.duplex_select = reg_wdata_i[mcsr_pkg::MCSR_MC_DUPLEX];
      mac_d.sqe_enable = reg_wdata_i[mcsr_pkg::MCSR_MC_SQE];
      mac_d.defer_check_disable = reg_wdata_i[mcsr_pkg::MCSR_MC_DEFER_DIS];
      mac_d.fcs_strip = reg_wdata_i[mcsr_pkg::MCSR_MC_FCS_STRIP];
      mac_d.fcs_check_disable = reg_wdata_i[mcsr_pkg::MCSR_MC_FCS_NOCHK];
    end
    if (wr_sel)
    begin
      sel_d.auto_inc = reg_wdata_i[mcsr_pkg::MCSR_CS_AUTO_INC];
      sel_d.clr_on_read = reg_wdata_i[mcsr_pkg::MCSR_CS_CLR_RD];
      sel_d.wr_mode = reg_wdata_i[mcsr_pkg::MCSR_CS_WR_MODE];
      sel_d.addr = reg_wdata_i[mcsr_pkg::MCSR_CS_ADDR_LSB +: mcsr_pkg::MCSR_CNT_ADDR_W];
    end
    else if (data_acc && sel_q.auto_inc)
      sel_d.addr = addr_inc;
    if (wr_mgmt)
      freeze_d = reg_wdata_i[mcsr_pkg::MCSR_CM_FREEZE];
    if (wr_snoop)
      snoop_d = reg_wdata_i[mcsr_pkg::MCSR_SNOOP_W-1:0];
    if (wr_idc)
      idc_d = reg_wdata_i[mcsr_pkg::MCSR_IDC_W-1:0];
  end

  // control state registers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mac_q <= mcsr_pkg::MCSR_MAC_CTL_RST;
      sel_q <= '0;
      freeze_q <= 1'b0;
      snoop_q <= '0;
      idc_q <= '0;
    end
    else
    begin
      mac_q <= mac_d;
      sel_q <= sel_d;
      freeze_q <= freeze_d;
      snoop_q <= snoop_d;
      idc_q <= idc_d;
    end
  end

  assign mac_ctl_o = mac_q;
  assign snoop_block_o = snoop_q;

  ////////////////////////////////////////////////////////////////////////////////
  // statistics counters

  logic [CNT_W-1:0] cnt_val [NUM_CNT];
  logic [NUM_CNT-1:0] cnt_pend;
  logic clr_rx, clr_tx;

  // write-one strobes, never stored
  assign clr_rx = wr_mgmt && reg_wdata_i[mcsr_pkg::MCSR_CM_CLR_RX];
  assign clr_tx = wr_mgmt && reg_wdata_i[mcsr_pkg::MCSR_CM_CLR_TX];

  for (genvar i = 0; i < NUM_CNT; i++)
  begin : g_cnt
    logic hit, is_rx, c_clr, c_load;
    // counter index i answers address i; the low block is transmit
    assign hit = (sel_q.addr == 6'(i));
    assign is_rx = (6'(i) >= mcsr_pkg::MCSR_RX_FIRST);
    assign c_load = hit && wr_data && sel_q.wr_mode;
    assign c_clr = (is_rx ? clr_rx : clr_tx) || (hit && rd_data && sel_q.clr_on_read);

    mcsr_stat_cnt #(
      .CNT_W(CNT_W),
      .PEND_W(PEND_W)
    ) u_cnt (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .evt_i(cnt_evt_i[i]),
      .freeze_i(freeze_q),
      .clr_i(c_clr),
      .load_i(c_load),
      .load_val_i(reg_wdata_i),
      .cnt_o(cnt_val[i]),
      .pend_o(cnt_pend[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive interrupt delay

  logic armed_q, armed_d;
  logic [mcsr_pkg::MCSR_IDC_W-1:0] dly_q, dly_d;
  logic int_q, int_d;

  // a new frame restarts the wait; the pulse fires once the byte count runs out
  always_comb
  begin
    armed_d = armed_q;
    dly_d = dly_q;
    int_d = 1'b0;
    if (rx_done_i)
    begin
      armed_d = 1'b1;
      dly_d = idc_q;
    end
    else if (armed_q && (dly_q == '0))
    begin
      armed_d = 1'b0;
      int_d = 1'b1;
    end
    else if (armed_q && byte_tick_i)
      dly_d = dly_q - mcsr_pkg::MCSR_IDC_W'(1);
  end

  // delay state registers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      armed_q <= 1'b0;
      dly_q <= '0;
      int_q <= 1'b0;
    end
    else
    begin
      armed_q <= armed_d;
      dly_q <= dly_d;
      int_q <= int_d;
    end
  end

  assign rx_int_o = int_q;

  ////////////////////////////////////////////////////////////////////////////////
  // read path

  logic [31:0] rdata_q, rdata_d;
  logic rvalid_q;
  logic [31:0] sel_word;

  always_comb
  begin
    sel_word = '0;
    sel_word[mcsr_pkg::MCSR_CS_AUTO_INC] = sel_q.auto_inc;
    sel_word[mcsr_pkg::MCSR_CS_CLR_RD] = sel_q.clr_on_read;
    sel_word[mcsr_pkg::MCSR_CS_WR_MODE] = sel_q.wr_mode;
    sel_word[mcsr_pkg::MCSR_CS_ADDR_LSB +: mcsr_pkg::MCSR_CNT_ADDR_W] = sel_q.addr;
  end

  // read data is sampled on the request edge; reserved bits and holes read zero
  always_comb
  begin
    rdata_d = '0;
    case (reg_addr_i)
      mcsr_pkg::MCSR_OFF_MAC_CTL:
      begin
        rdata_d[mcsr_pkg::MCSR_MC_DUPLEX] = mac_q.duplex_select;
        rdata_d[mcsr_pkg::MCSR_MC_SQE] = mac_q.sqe_enable;
        rdata_d[mcsr_pkg::MCSR_MC_DEFER_DIS] = mac_q.defer_check_disable;
        rdata_d[mcsr_pkg::MCSR_MC_FCS_STRIP] = mac_q.fcs_strip;
        rdata_d[mcsr_pkg::MCSR_MC_FCS_NOCHK] = mac_q.fcs_check_disable;
      end
      mcsr_pkg::MCSR_OFF_CNT_DATA:
        // addresses past the last counter read zero
        if (sel_q.addr <= mcsr_pkg::MCSR_RX_LAST)
          rdata_d = cnt_val[sel_q.addr];
      mcsr_pkg::MCSR_OFF_CNT_SEL:
        rdata_d = sel_word;
      mcsr_pkg::MCSR_OFF_CNT_MGMT:
        // freeze reads set until buffered events have been folded in
        rdata_d[mcsr_pkg::MCSR_CM_FREEZE] = freeze_q || (|cnt_pend);
      mcsr_pkg::MCSR_OFF_SNOOP:
        rdata_d[mcsr_pkg::MCSR_SNOOP_W-1:0] = snoop_q;
      mcsr_pkg::MCSR_OFF_IDC:
        rdata_d[mcsr_pkg::MCSR_IDC_W-1:0] = idc_q;
      default:
        rdata_d = '0;
    endcase
  end

  // read answer registers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q <= reg_rd_i ? rdata_d : rdata_q;
      rvalid_q <= reg_rd_i;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;

endmodule

// [dv/mcsr_regs_props.sv]
// checker for the mac control and statistics register group
// assumes it is bound into mcsr_regs and sees only that module's ports
`timescale 1ns/1ns

module mcsr_regs_props (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [8:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  // controls
  input wire mcsr_pkg::mcsr_mac_ctl_t mac_ctl_o,
  input wire logic [mcsr_pkg::MCSR_SNOOP_W-1:0] snoop_block_o
);
  // decoded accesses, kept as plain nets so each property stays short
  wire w_mac = reg_wr_i && reg_addr_i == mcsr_pkg::MCSR_OFF_MAC_CTL;
  wire w_snp = reg_wr_i && reg_addr_i == mcsr_pkg::MCSR_OFF_SNOOP;
  wire r_cm = reg_rd_i && reg_addr_i == mcsr_pkg::MCSR_OFF_CNT_MGMT;
  wire r_cs = reg_rd_i && reg_addr_i == mcsr_pkg::MCSR_OFF_CNT_SEL;
  wire r_id = reg_rd_i && reg_addr_i == mcsr_pkg::MCSR_OFF_IDC;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  ////////////////////////////////////////////////////////////////////////////////
  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read got no answer");
  a_answer_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("answer without read");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  a_duplex_write: assert property (w_mac |=> mac_ctl_o.duplex_select == $past(reg_wdata_i[6]))
    else $error("duplex bit not written");
  a_check_bits: assert property (w_mac |=> mac_ctl_o[2:0] ==
    {$past(reg_wdata_i[4]), $past(reg_wdata_i[1]), $past(reg_wdata_i[0])})
    else $error("check bits not written");
  a_mac_hold: assert property (!w_mac |=> $stable(mac_ctl_o))
    else $error("mac controls moved");
  a_snoop_write: assert property (w_snp |=> snoop_block_o == $past(reg_wdata_i[6:0]))
    else $error("snoop pointer not written");
  a_snoop_hold: assert property (!w_snp |=> $stable(snoop_block_o))
    else $error("snoop pointer moved");
  a_strobe_read: assert property (r_cm |=> reg_rdata_o[1:0] == 2'h0)
    else $error("clear strobes read back");
  a_select_width: assert property (r_cs |=> reg_rdata_o[31:11] == 0 && reg_rdata_o[7:6] == 0)
    else $error("select reserved bits set");
  a_delay_width: assert property (r_id |=> reg_rdata_o[31:24] == 8'h0)
    else $error("delay reserved bits set");
endmodule

bind mcsr_regs mcsr_regs_props u_props (.ref_clk_i, .sys_rst_i, .reg_wr_i, .reg_rd_i,
  .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .mac_ctl_o, .snoop_block_o);

// [dv/test_mac_ctl_stats_regs.sv]
// self-checking bench for the mac control and statistics register group
// assumes mcsr_regs with default parameters and its checker bound beside it
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end

module test_mac_ctl_stats_regs;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [8:0] reg_addr_i = 9'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] reg_rdata_o;
  logic reg_rvalid_o;
  mcsr_pkg::mcsr_mac_ctl_t mac_ctl_o;
  logic [mcsr_pkg::MCSR_NUM_CNT-1:0] cnt_evt_i = '0;
  logic [mcsr_pkg::MCSR_SNOOP_W-1:0] snoop_block_o;
  logic rx_done_i = 1'b0;
  logic byte_tick_i = 1'b0;
  logic rx_int_o;
  int bad_count = 0;
  int tests_run = 0;
  int n;
  logic [31:0] rv;
  logic [31:0] d;
  logic [8:0] offs [5] = '{9'h154, 9'h168, 9'h170, 9'h180, 9'h160};
  logic [31:0] msk [5] = '{32'h73, 32'h73F, 32'h7F, 32'hFFFFFF, 32'h0};
  logic [31:0] dl [4] = '{32'h0, 32'h1, 32'h5, 32'h0};

  // expected mac control outputs after a write of v: bits 6,5,4,1,0 in struct order
  function automatic mcsr_pkg::mcsr_mac_ctl_t exp_mac(input logic [31:0] v);
    return {v[6:4], v[1:0]};
  endfunction

  // expected read back of register k after a write of v: only its defined fields stick
  function automatic logic [31:0] exp_rd(input int k, input logic [31:0] v);
    return v & msk[k];
  endfunction

  mcsr_regs dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .mac_ctl_o(mac_ctl_o),
    .cnt_evt_i(cnt_evt_i), .snoop_block_o(snoop_block_o), .rx_done_i(rx_done_i),
    .byte_tick_i(byte_tick_i), .rx_int_o(rx_int_o));

  // 250 MHz clock
  initial
  begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // inputs always move one ns after the edge so no race with the sampling edge
  task step;
    @(posedge ref_clk_i);
    #1;
  endtask

  task print_verdict;
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // an idle cycle leads each access so a strobe never toggles twice in one step
  task wr(input logic [8:0] a, input logic [31:0] v);
    step;
    reg_addr_i = a;
    reg_wdata_i = v;
    reg_wr_i = 1'b1;
    step;
    reg_wr_i = 1'b0;
  endtask

  task chk_rd(input logic [8:0] a, input logic [31:0] e);
    step;
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    step;
    reg_rd_i = 1'b0;
    `CHK(reg_rvalid_o, 1'b1)
    `CHK(reg_rdata_o, e)
  endtask

  task evt(input int i, input int k);
    repeat (k)
    begin
      step;
      cnt_evt_i[i] = 1'b1;
      step;
      cnt_evt_i[i] = 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hFC23));
    repeat (4) @(posedge ref_clk_i);
    #1 sys_rst_i = 1'b0;
    `CHK(mac_ctl_o, mcsr_pkg::MCSR_MAC_CTL_RST)
    chk_rd(9'h164, 32'h0);
    chk_rd(9'h16C, 32'h0);
    // reset values, then random writes read back through the field masks
    for (int k = 0; k < 5; k++)
    begin
      chk_rd(offs[k], (k == 0) ? 32'h50 : 32'h0);
      repeat (4)
      begin
        d = $urandom;
        // software never asks for strip without checking
        if (k == 0)
          d[0] = d[0] & ~d[1];
        wr(offs[k], d);
        chk_rd(offs[k], exp_rd(k, d));
        if (k == 0)
          `CHK(mac_ctl_o, exp_mac(d))
        if (k == 2)
          `CHK(snoop_block_o, d[6:0])
      end
    end
    // counting, write mode, auto-increment across the wrap, clear on read
    wr(9'h168, 32'h0E);
    evt(14, 3);
    chk_rd(9'h164, 32'h3);
    d = $urandom;
    wr(9'h168, 32'h125);
    wr(9'h164, d);
    wr(9'h168, 32'h625);
    chk_rd(9'h164, d);
    chk_rd(9'h164, 32'h0);
    chk_rd(9'h168, 32'h601);
    wr(9'h168, 32'h25);
    chk_rd(9'h164, 32'h0);
    wr(9'h168, 32'h0F);
    wr(9'h164, 32'h5);
    chk_rd(9'h164, 32'h0);
    evt(15, 2);
    wr(9'h168, 32'h30);
    chk_rd(9'h164, 32'h0);
    // freeze holds values and applies the buffered events afterwards
    wr(9'h16C, 32'h4);
    evt(15, 3);
    wr(9'h168, 32'h0F);
    chk_rd(9'h164, 32'h2);
    chk_rd(9'h16C, 32'h4);
    wr(9'h16C, 32'h0);
    repeat (2) step;
    chk_rd(9'h164, 32'h5);
    // clear strobes touch only their own direction
    wr(9'h168, 32'h0E);
    wr(9'h16C, 32'h1);
    chk_rd(9'h164, 32'h0);
    wr(9'h168, 32'h0F);
    chk_rd(9'h164, 32'h5);
    wr(9'h16C, 32'h2);
    chk_rd(9'h164, 32'h0);
    // write mode with auto-increment loads two neighbours, one per access
    d = $urandom;
    wr(9'h168, 32'h50E);
    wr(9'h164, d);
    wr(9'h164, ~d);
    chk_rd(9'h168, 32'h510);
    wr(9'h168, 32'h0E);
    chk_rd(9'h164, d);
    wr(9'h168, 32'h0F);
    chk_rd(9'h164, ~d);
    // interrupt delay: ticks every other cycle, count ticks until the pulse
    dl[3] = 32'h1 + ($urandom % 20);
    foreach (dl[k])
    begin
      wr(9'h180, dl[k]);
      step;
      rx_done_i = 1'b1;
      step;
      rx_done_i = 1'b0;
      n = 0;
      for (int j = 1; j <= 100; j++)
      begin
        step;
        if (rx_int_o === 1'b1)
          break;
        byte_tick_i = (j % 2 == 0);
        n += (j % 2 == 0);
        if (j == 100)
        begin
          bad_count++;
          print_verdict;
        end
      end
      `CHK(n, int'(dl[k]))
      step;
      `CHK(rx_int_o, 1'b0)
    end
    print_verdict;
  end
endmodule
